// [design/lcr_defs.svh]
// What this block does
// [R1] bit 0 set powers down amplifier, open loop
// [R2] two-bit field selects 0.75 to 1.5 mA
// [R3] channel 2 upper nibbles: gain high, offset low
// [R4] channel 2 gain low byte from 0x12
// [R5] channel 2 offset low byte from 0x13
// [R6] channel 1 upper nibbles: gain high, offset low
// [R7] codes follow register contents at once, unstaged
//
// constants for the laser driver configuration register slice
// assumes a register port of byte address, byte data, write and read strobes
`ifndef LCR_DEFS_SVH
`define LCR_DEFS_SVH

// =====================================================
// offsets
`define LCR_ADDR_MON_CTRL 8'h0e
`define LCR_ADDR_SPARE_A 8'h0f
`define LCR_ADDR_SPARE_B 8'h10
`define LCR_ADDR_CH2_UPPER 8'h11
`define LCR_ADDR_CH2_GAIN_LO 8'h12
`define LCR_ADDR_CH2_OFFS_LO 8'h13
`define LCR_ADDR_CH1_UPPER 8'h14

// =====================================================
// reset values
`define LCR_RST_MON_CTRL 8'h0a
`define LCR_RST_ZERO 8'h00

// =====================================================
// field positions
`define LCR_PD_BIT 0
`define LCR_HICUR_HI 6
`define LCR_HICUR_LO 5
`define LCR_MON_MASK 8'h61

// =====================================================
// amplifier current settings, in hundredths of a milliampere
`define LCR_CENTI_MA_0 8'h4b
`define LCR_CENTI_MA_1 8'h64
`define LCR_CENTI_MA_2 8'h7d
`define LCR_CENTI_MA_3 8'h96

`endif

// [design/lcr_pkg.sv]
// types for the laser driver configuration register slice
// select codes are literal here; lcr_defs.svh holds the other numeric constants
package lcr_pkg;

    // current range select codes, 0.75 mA to 1.5 mA in 0.25 mA steps
    typedef enum logic [1:0] {
        LCR_CUR_0P75 = 2'h0,
        LCR_CUR_1P00 = 2'h1,
        LCR_CUR_1P25 = 2'h2,
        LCR_CUR_1P50 = 2'h3
    } lcr_cur_sel_t;

    typedef struct packed {
        logic amplifier_power_down;
        lcr_cur_sel_t cur_sel;
    } lcr_mon_cfg_t;

    typedef struct packed {
        logic [11:0] ch2_gain_code;
        logic [11:0] ch2_offset_code;
        logic [3:0] ch1_gain_hi;
        logic [3:0] ch1_offset_hi;
    } lcr_codes_t;

endpackage : lcr_pkg

// [design/lcr_regs.sv]
// register slice 0x0e..0x14 of the laser driver configuration bank
// assumes write and read strobes arrive synchronous to clk_sys
`timescale 1ns/1ps
`include "lcr_defs.svh"

module lcr_regs
    import lcr_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    // configuration outputs
    output lcr_mon_cfg_t mon_cfg,
    output logic [7:0] tia_cur_centi_ma,
    output lcr_codes_t codes
);

    // =====================================================
    // storage
    logic [7:0] mon_reg, spare_a_reg, spare_b_reg;
    logic [7:0] ch2_up_reg, ch2_glo_reg, ch2_olo_reg, ch1_up_reg;
    logic [7:0] rdata_reg;
    logic [7:0] tia_reg;

    // =====================================================
    // assertion clocking, shared by every check in this file
    default clocking cb_sys @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // =====================================================
    // decode
    wire sel_mon = reg_addr == `LCR_ADDR_MON_CTRL;
    wire sel_sa = reg_addr == `LCR_ADDR_SPARE_A;
    wire sel_sb = reg_addr == `LCR_ADDR_SPARE_B;
    wire sel_c2u = reg_addr == `LCR_ADDR_CH2_UPPER;
    wire sel_c2g = reg_addr == `LCR_ADDR_CH2_GAIN_LO;
    wire sel_c2o = reg_addr == `LCR_ADDR_CH2_OFFS_LO;
    wire sel_c1u = reg_addr == `LCR_ADDR_CH1_UPPER;
    wire any_sel = sel_mon | sel_sa | sel_sb | sel_c2u | sel_c2g
        | sel_c2o | sel_c1u;
    // reserved bits of the monitor control keep their default pattern,
    // so writes cannot disturb them and a read shows the default
    wire [7:0] mon_keep = `LCR_RST_MON_CTRL & ~`LCR_MON_MASK;
    wire [7:0] mon_next = (reg_wdata & `LCR_MON_MASK) | mon_keep;
    wire [7:0] rd_mux;
    assign rd_mux = sel_mon ? mon_reg :
        sel_sa ? spare_a_reg :
        sel_sb ? spare_b_reg :
        sel_c2u ? ch2_up_reg :
        sel_c2g ? ch2_glo_reg :
        sel_c2o ? ch2_olo_reg :
        sel_c1u ? ch1_up_reg : `LCR_RST_ZERO;
    assign reg_hit = any_sel;

    // =====================================================
    // current range lookup, taken from the value being written
    wire [1:0] wr_cur_sel = mon_next[`LCR_HICUR_HI:`LCR_HICUR_LO];
    wire [7:0] tia_next;
    assign tia_next = (wr_cur_sel == LCR_CUR_1P50) ? `LCR_CENTI_MA_3 :
        (wr_cur_sel == LCR_CUR_1P25) ? `LCR_CENTI_MA_2 :
        (wr_cur_sel == LCR_CUR_1P00) ? `LCR_CENTI_MA_1 :
        `LCR_CENTI_MA_0; // R2

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mon_reg <= `LCR_RST_MON_CTRL;
            spare_a_reg <= `LCR_RST_ZERO;
            spare_b_reg <= `LCR_RST_ZERO;
            ch2_up_reg <= `LCR_RST_ZERO;
            ch2_glo_reg <= `LCR_RST_ZERO;
            ch2_olo_reg <= `LCR_RST_ZERO;
            ch1_up_reg <= `LCR_RST_ZERO;
            rdata_reg <= `LCR_RST_ZERO;
            tia_reg <= `LCR_CENTI_MA_0;
        end else begin
            if (reg_wr && sel_mon) mon_reg <= mon_next; // R1 R2
            if (reg_wr && sel_mon) tia_reg <= tia_next; // R2
            if (reg_wr && sel_sa) spare_a_reg <= reg_wdata;
            if (reg_wr && sel_sb) spare_b_reg <= reg_wdata;
            if (reg_wr && sel_c2u) ch2_up_reg <= reg_wdata; // R3
            if (reg_wr && sel_c2g) ch2_glo_reg <= reg_wdata; // R4
            if (reg_wr && sel_c2o) ch2_olo_reg <= reg_wdata; // R5
            if (reg_wr && sel_c1u) ch1_up_reg <= reg_wdata; // R6
            if (reg_rd) rdata_reg <= rd_mux;
        end
    end
    assign reg_rdata = rdata_reg;

    // =====================================================
    // outputs straight from the registers, no staging
    assign mon_cfg.amplifier_power_down = mon_reg[`LCR_PD_BIT]; // R1
    assign mon_cfg.cur_sel =
        lcr_cur_sel_t'(mon_reg[`LCR_HICUR_HI:`LCR_HICUR_LO]); // R2
    assign tia_cur_centi_ma = tia_reg; // R2
    assign codes.ch2_gain_code = {ch2_up_reg[7:4], ch2_glo_reg}; // R3 R4 R7
    assign codes.ch2_offset_code = {ch2_up_reg[3:0], ch2_olo_reg}; // R3 R5 R7
    assign codes.ch1_gain_hi = ch1_up_reg[7:4]; // R6
    assign codes.ch1_offset_hi = ch1_up_reg[3:0]; // R6

    // =====================================================
    // checks: monitor front-end control
    a_pd_follows_write: assert property ( // R1
        reg_wr && sel_mon
        |=> mon_cfg.amplifier_power_down == $past(reg_wdata[`LCR_PD_BIT]))
        else $error("power down bit not taken");

    a_cur_follows_write: assert property ( // R2
        reg_wr && sel_mon
        |=> mon_cfg.cur_sel
            == $past(reg_wdata[`LCR_HICUR_HI:`LCR_HICUR_LO]))
        else $error("current select not taken");

    a_cur_map: assert property ( // R2
        tia_cur_centi_ma == 8'h4b + 8'h19 * mon_cfg.cur_sel)
        else $error("current select map wrong");

    a_mon_stable: assert property ( // R1
        !(reg_wr && sel_mon)
        |=> $stable(mon_cfg) && $stable(tia_cur_centi_ma))
        else $error("monitor control moved without write");

    // reserved bits must read back their default pattern
    a_mon_readback: assert property ( // R1 R2
        reg_rd && sel_mon
        |=> reg_rdata[`LCR_PD_BIT] == $past(mon_cfg.amplifier_power_down)
            && reg_rdata[`LCR_HICUR_HI:`LCR_HICUR_LO]
                == $past(mon_cfg.cur_sel)
            && (reg_rdata & ~`LCR_MON_MASK)
                == (`LCR_RST_MON_CTRL & ~`LCR_MON_MASK))
        else $error("monitor control read back wrong");

    // =====================================================
    // checks: code assembly
    // each byte shows on the code outputs one edge after its write
    a_ch2_gain_hi: assert property ( // R3
        reg_wr && sel_c2u
        |=> codes.ch2_gain_code[11:8] == $past(reg_wdata[7:4]))
        else $error("ch2 gain nibble wrong");

    a_ch2_offs_hi: assert property ( // R3
        reg_wr && sel_c2u
        |=> codes.ch2_offset_code[11:8] == $past(reg_wdata[3:0]))
        else $error("ch2 offset nibble wrong");

    a_ch2_gain_lo: assert property ( // R4
        reg_wr && sel_c2g
        |=> codes.ch2_gain_code[7:0] == $past(reg_wdata))
        else $error("ch2 gain low byte wrong");

    a_ch2_offs_lo: assert property ( // R5
        reg_wr && sel_c2o
        |=> codes.ch2_offset_code[7:0] == $past(reg_wdata))
        else $error("ch2 offset low byte wrong");

    a_ch1_nibbles: assert property ( // R6
        reg_wr && sel_c1u
        |=> {codes.ch1_gain_hi, codes.ch1_offset_hi} == $past(reg_wdata))
        else $error("ch1 nibbles wrong");

    a_ch1_stable: assert property ( // R6
        !(reg_wr && sel_c1u)
        |=> $stable({codes.ch1_gain_hi, codes.ch1_offset_hi}))
        else $error("ch1 nibbles moved without write");

    a_gain_stable: assert property ( // R7
        !(reg_wr && (sel_c2u || sel_c2g))
        |=> $stable(codes.ch2_gain_code))
        else $error("ch2 gain moved without write");

    a_offs_stable: assert property ( // R7
        !(reg_wr && (sel_c2u || sel_c2o))
        |=> $stable(codes.ch2_offset_code))
        else $error("ch2 offset moved without write");

    // no staging: an upper write leaves the low byte as it was
    a_low_byte_kept: assert property ( // R7
        reg_wr && sel_c2u
        |=> codes.ch2_gain_code[7:0] == $past(codes.ch2_gain_code[7:0]))
        else $error("upper write disturbed gain low byte");

    // =====================================================
    // checks: register port
    a_hit_decode: assert property (
        reg_hit == (reg_addr >= `LCR_ADDR_MON_CTRL
            && reg_addr <= `LCR_ADDR_CH1_UPPER))
        else $error("address hit decode wrong");

    a_unmapped_read: assert property (
        reg_rd && !reg_hit |=> reg_rdata == `LCR_RST_ZERO)
        else $error("unmapped read not zero");

    a_unmapped_write: assert property (
        reg_wr && !reg_hit |=> $stable(codes) && $stable(mon_cfg))
        else $error("unmapped write changed a register");

    a_rdata_holds: assert property (
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without read");

    a_rd_gain_lo: assert property ( // R4
        reg_rd && sel_c2g
        |=> reg_rdata == $past(codes.ch2_gain_code[7:0]))
        else $error("gain low byte read back wrong");

    a_rd_ch1: assert property ( // R6
        reg_rd && sel_c1u
        |=> reg_rdata == $past({codes.ch1_gain_hi, codes.ch1_offset_hi}))
        else $error("ch1 nibbles read back wrong");

    // =====================================================
    // covers for the main scenarios
    c_pd_set: cover property ($rose(mon_cfg.amplifier_power_down));
    c_cur_max: cover property (mon_cfg.cur_sel == LCR_CUR_1P50);
    c_gain_both: cover property (
        codes.ch2_gain_code[11:8] != 4'h0
        && codes.ch2_gain_code[7:0] != 8'h00);
    c_upper_then_low: cover property (
        (reg_wr && sel_c2u) ##2 (reg_wr && sel_c2g));
    c_unmapped_read: cover property (reg_rd && !reg_hit);

endmodule : lcr_regs

// [test/lcr_host.sv]
// host model driving the register port of the configuration slice
// assumes strobes are sampled on the rising edge of clk_sys
`timescale 1ns/1ps

module lcr_host (
    // clock
    input wire logic clk_sys,
    // register port
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_hit
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // released lines show the inverse so stale values are never trusted
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d,
        output logic h);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        h = reg_hit;
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask : rd
endmodule : lcr_host

// [test/testbench.sv]
// self-checking bench for the configuration register slice
// assumes lcr_host as the register port master
`timescale 1ns/1ps
`include "lcr_defs.svh"

module testbench import lcr_pkg::*;;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, tia, d;
    logic reg_wr, reg_rd, reg_hit, h;
    lcr_mon_cfg_t mon_cfg;
    lcr_codes_t codes;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;

    always #5 clk_sys = ~clk_sys;

    lcr_regs DUT (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_hit(reg_hit), .mon_cfg(mon_cfg),
        .tia_cur_centi_ma(tia), .codes(codes));
    lcr_host host (.clk_sys(clk_sys), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_hit(reg_hit));

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task rd_chk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, d, h);
        chk(d, e);
        chk(h, a >= `LCR_ADDR_MON_CTRL && a <= `LCR_ADDR_CH1_UPPER);
    endtask : rd_chk

    task wrap_up;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            wrap_up;
        end
    end

    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        // ===================== reset values
        for (int a = 8'h0f; a <= 8'h14; a++) rd_chk(a[7:0], `LCR_RST_ZERO);
        rd_chk(`LCR_ADDR_MON_CTRL, `LCR_RST_MON_CTRL);
        chk(tia, 8'h4b);
        $display("test reset done");
        // ===================== monitor control, reserved bits set
        for (int i = 0; i < 4; i++) begin
            host.wr(`LCR_ADDR_MON_CTRL, {1'b1, i[1:0], 4'hf, i[0]});
            chk(mon_cfg.amplifier_power_down, i[0]);
            chk(mon_cfg.cur_sel, i[1:0]);
            chk(tia, 8'h4b + 8'h19 * i[7:0]);
            rd_chk(`LCR_ADDR_MON_CTRL, {1'b0, i[1:0], 4'h5, i[0]});
        end
        $display("test monitor done");
        // ===================== code assembly, each byte visible at once
        host.wr(`LCR_ADDR_CH2_UPPER, 8'ha5);
        chk(codes.ch2_gain_code, 12'ha00);
        chk(codes.ch2_offset_code, 12'h500);
        host.wr(`LCR_ADDR_CH2_GAIN_LO, 8'h3c);
        chk(codes.ch2_gain_code, 12'ha3c);
        host.wr(`LCR_ADDR_CH2_OFFS_LO, 8'hd2);
        chk(codes.ch2_offset_code, 12'h5d2);
        host.wr(`LCR_ADDR_CH1_UPPER, 8'h96);
        chk({codes.ch1_gain_hi, codes.ch1_offset_hi}, 8'h96);
        rd_chk(`LCR_ADDR_CH1_UPPER, 8'h96);
        rd_chk(`LCR_ADDR_CH2_GAIN_LO, 8'h3c);
        $display("test codes done");
        // ===================== spare and unmapped places
        host.wr(`LCR_ADDR_SPARE_A, 8'h55);
        rd_chk(`LCR_ADDR_SPARE_A, 8'h55);
        host.wr(8'h15, 8'hff);
        rd_chk(8'h15, 8'h00);
        chk(codes, 32'ha3c5d296);
        $display("test unmapped done");
        wrap_up;
    end
endmodule : testbench
